// >>> inc/cpr_params.svh
// Purpose: constants of the port option and receive block
// Assumes: 20 MHz clock
// Notes:   timing counts derive from the clock rate
`ifndef CPR_PARAMS_SVH
`define CPR_PARAMS_SVH

`define CPR_CLK_HZ          20000000
`define CPR_TS_RES_NS       100
`define CPR_TS_TICK_CYC     ((`CPR_TS_RES_NS * (`CPR_CLK_HZ / 1000000)) / 1000)
`define CPR_WAIT_MS_NS      1000000
`define CPR_MS_CYC          ((`CPR_WAIT_MS_NS / 1000) * (`CPR_CLK_HZ / 1000000))
`define CPR_WAIT_DEFAULT    32'sd10000
`define CPR_WAIT_FOREVER    -32'sd1
`define CPR_ID_EXT_BIT      29
`define CPR_STORE_DEPTH     2
`define CPR_MAX_CLASSIC_LEN 8'h08
`define CPR_MAX_FD_LEN      8'h40
`define CPR_FRAME_WORDS     20

`endif

// >>> inc/cpr_pkg.sv
// Purpose: types of the port option and receive block
// Assumes: cpr_params.svh supplies the numbers
// Notes:   one frame record moves through the receive path
package cpr_pkg;

    // one received frame or logged bus error
    typedef struct packed {
        logic [63:0]      stamp;
        logic [31:0]      ident;
        logic [7:0]       kind;
        logic [7:0]       info_a;
        logic [7:0]       info_b;
        logic [7:0]       length;
        logic [511:0]     payload;
    } cpr_frame_type;

    // per-read outcome
    typedef struct packed {
        logic             error;
        logic             overflow;
        logic             timeout;
    } cpr_status_type;

    // configuration straps
    typedef struct packed {
        logic             echo_on;
        logic             single_shot;
        logic             listen_only;
        logic             log_bus_errors;
        logic             word_format;
    } cpr_config_type;

    // read engine states
    typedef enum logic [3:0] {
        CPR_IDLE = 4'b0001,
        CPR_WAIT = 4'b0010,
        CPR_SEND = 4'b0100,
        CPR_WORD = 4'b1000
    } cpr_read_state_type;

endpackage : cpr_pkg

// >>> hdl/cpr_stamp.sv
// Purpose: relative 64-bit receive time counter
// Assumes: start pulse marks communication start
// Notes:   one tick per resolution interval
`include "cpr_params.svh"
`timescale 1ns/10ps
`default_nettype none

module cpr_stamp (
    // clock and reset
    input  wire logic        mclk_in,
    input  wire logic        reset_n_in,
    // control
    input  wire logic        start_in,
    input  wire logic        running_in,
    // time value
    output logic [63:0]      stamp_out
);
    import cpr_pkg::*;

    localparam int TICK = (`CPR_TS_TICK_CYC < 1) ? 1 : `CPR_TS_TICK_CYC;

    logic [7:0]  div;
    logic [7:0]  next_div;
    logic [63:0] next_stamp;

    // divider gives a one-cycle tick; start zeroes both
    always_comb begin
        next_div   = div;
        next_stamp = stamp_out;
        if (start_in) begin
            next_div   = 8'h00;
            next_stamp = 64'h0;
        end else if (running_in) begin
            if (div == 8'(TICK - 1)) begin
                next_div   = 8'h00;
                next_stamp = stamp_out + 64'h1;
            end else begin
                next_div = div + 8'h01;
            end
        end
    end

    // width avoids any rollover handling
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            div       <= 8'h00;
            stamp_out <= 64'h0;
        end else begin
            div       <= next_div;
            stamp_out <= next_stamp;
        end
    end

endmodule : cpr_stamp
`default_nettype wire

// >>> hdl/cpr_store.sv
// Purpose: two-entry store of unread frames
// Assumes: one push and one pop per cycle at most
// Notes:   push into a full store without a pop in the same cycle is dropped and flagged
`include "cpr_params.svh"
`timescale 1ns/10ps
`default_nettype none

module cpr_store (
    // clock and reset
    input  wire logic                  mclk_in,
    input  wire logic                  reset_n_in,
    input  wire logic                  flush_in,
    // fill side
    input  wire logic                  push_in,
    input  wire cpr_pkg::cpr_frame_type push_frame_in,
    // drain side
    input  wire logic                  pop_in,
    output logic                       valid_out,
    output cpr_pkg::cpr_frame_type     head_out,
    // full store hit by a push
    output logic                       overflow_out
);
    import cpr_pkg::*;

    cpr_frame_type entry [`CPR_STORE_DEPTH];
    cpr_frame_type next_entry [`CPR_STORE_DEPTH];
    logic [1:0]    count;
    logic [1:0]    next_count;
    logic          do_pop;

    assign valid_out    = (count != 2'd0);
    assign head_out     = entry[0];
    assign overflow_out = push_in && (count == 2'd2) && !pop_in;
    assign do_pop       = pop_in && valid_out;

    // shift down on pop, write at tail on push
    always_comb begin
        next_entry = entry;
        next_count = count;
        if (do_pop) begin
            next_entry[0] = entry[1];
            next_count    = count - 2'd1;
        end
        if (push_in && !overflow_out) begin
            next_entry[next_count[0]] = push_frame_in;
            next_count                = next_count + 2'd1;
        end
        if (flush_in) begin
            next_count = 2'd0;
        end
    end

    // entries hold no reset; count decides validity
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            count <= 2'd0;
        end else begin
            count <= next_count;
        end
    end

    always_ff @(posedge mclk_in) begin
        entry <= next_entry;
    end

endmodule : cpr_store
`default_nettype wire

// >>> hdl/cpr_port.sv
// Purpose: port options and receive path of a CAN port
// Assumes: protocol engine gives frame-end and transmit result pulses
// Notes:   options are straps, read combinationally every cycle, so they act at once
`include "cpr_params.svh"
`timescale 1ns/10ps
`default_nettype none

module cpr_port (
    // clock and reset
    input  wire logic                   mclk_in,
    input  wire logic                   reset_n_in,
    // configuration
    input  wire cpr_pkg::cpr_config_type config_in,
    input  wire logic signed [31:0]     receive_wait_limit_in,
    input  wire logic                   auto_start_in,
    input  wire logic                   start_in,
    input  wire logic                   stop_in,
    // protocol engine, receive side
    input  wire logic                   rx_done_in,
    input  wire logic [31:0]            rx_ident_in,
    input  wire logic [7:0]             rx_kind_in,
    input  wire logic [7:0]             rx_length_in,
    input  wire logic                   rx_fd_in,
    input  wire logic [511:0]           rx_payload_in,
    input  wire logic                   bus_error_in,
    input  wire logic [7:0]             bus_error_kind_in,
    // protocol engine, transmit side
    input  wire logic                   tx_request_in,
    input  wire logic [31:0]            tx_ident_in,
    input  wire logic [7:0]             tx_length_in,
    input  wire logic [511:0]           tx_payload_in,
    input  wire logic                   tx_done_in,
    input  wire logic                   tx_fail_in,
    output logic                        tx_start_out,
    output logic                        tx_refused_out,
    output logic                        ack_enable_out,
    output logic                        error_passive_out,
    output logic                        running_out,
    // read request from user logic
    input  wire logic                   read_req_in,
    input  wire logic                   read_ready_in,
    output logic                        read_busy_out,
    output logic                        read_done_out,
    output cpr_pkg::cpr_status_type     read_status_out,
    output cpr_pkg::cpr_frame_type      received_frame_output_out,
    output logic                        word_valid_out,
    output logic [31:0]                 word_out,
    output logic [4:0]                  word_index_out
);
    import cpr_pkg::*;

    localparam int MS_CYC = `CPR_MS_CYC;
    localparam logic [7:0] KIND_BUS_ERROR = 8'h06;

    // ------------------------------------------------------------
    // communication state and timestamp
    // ------------------------------------------------------------
    logic        running;
    logic        next_running;
    logic        boot;
    logic        next_boot;
    logic        start_pulse;
    logic [63:0] stamp;

    // auto start fires once after reset; explicit start any time
    always_comb begin
        next_boot    = 1'b0;
        start_pulse  = start_in || (boot && auto_start_in);
        next_running = running;
        if (start_pulse) begin
            next_running = 1'b1;
        end else if (stop_in) begin
            next_running = 1'b0;
        end
    end

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            running <= 1'b0;
            boot    <= 1'b1;
        end else begin
            running <= next_running;
            boot    <= next_boot;
        end
    end

    assign running_out = running;

    cpr_stamp u_stamp (
        .mclk_in    (mclk_in),
        .reset_n_in (reset_n_in),
        .start_in   (start_pulse),
        .running_in (running),
        .stamp_out  (stamp)
    );

    // ------------------------------------------------------------
    // transmit options
    // ------------------------------------------------------------
    logic tx_pending;
    logic next_tx_pending;
    logic tx_start;

    // listen only gates requests; single shot drops on failure
    always_comb begin
        next_tx_pending = tx_pending;
        tx_start        = 1'b0;
        if (!tx_pending && tx_request_in && running && !config_in.listen_only) begin
            next_tx_pending = 1'b1;
            tx_start        = 1'b1;
        end else if (tx_pending && tx_done_in) begin
            next_tx_pending = 1'b0;
        end else if (tx_pending && tx_fail_in) begin
            if (config_in.single_shot) begin
                next_tx_pending = 1'b0;
            end else begin
                tx_start = 1'b1;
            end
        end
        if (!running) begin
            next_tx_pending = 1'b0;
        end
    end

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            tx_pending <= 1'b0;
        end else begin
            tx_pending <= next_tx_pending;
        end
    end

    assign tx_start_out      = tx_start;
    assign tx_refused_out    = tx_request_in && config_in.listen_only;
    assign ack_enable_out    = running && !config_in.listen_only;
    assign error_passive_out = config_in.listen_only;

    // ------------------------------------------------------------
    // capture of frames into the store
    // ------------------------------------------------------------
    cpr_frame_type cap;
    logic          push;
    logic          store_valid;
    logic          store_over;
    logic          pop;
    cpr_frame_type head;
    logic          echo;
    logic [7:0]    len_cap;

    // own good transmit beats a bus frame in the same cycle (never both)
    assign echo = tx_pending && tx_done_in && config_in.echo_on;

    always_comb begin
        len_cap = rx_fd_in ? `CPR_MAX_FD_LEN : `CPR_MAX_CLASSIC_LEN;
        cap         = '0;
        cap.stamp   = stamp;
        push        = 1'b0;
        if (echo) begin
            cap.ident   = tx_ident_in;
            cap.length  = tx_length_in;
            cap.payload = tx_payload_in;
            push        = running;
        end else if (rx_done_in) begin
            cap.ident   = rx_ident_in;
            cap.kind    = rx_kind_in;
            cap.length  = (rx_length_in > len_cap) ? len_cap : rx_length_in;
            cap.payload = rx_payload_in;
            push        = running;
        end else if (bus_error_in && config_in.log_bus_errors) begin
            cap.kind   = KIND_BUS_ERROR;
            cap.info_a = bus_error_kind_in;
            push       = running;
        end
    end

    cpr_store u_store (
        .mclk_in       (mclk_in),
        .reset_n_in    (reset_n_in),
        .flush_in      (start_pulse),
        .push_in       (push),
        .push_frame_in (cap),
        .pop_in        (pop),
        .valid_out     (store_valid),
        .head_out      (head),
        .overflow_out  (store_over)
    );

    // ------------------------------------------------------------
    // read engine
    // ------------------------------------------------------------
    cpr_read_state_type state;
    cpr_read_state_type next_state;
    logic               over_sticky;
    logic               next_over_sticky;
    logic [31:0]        ms_left;
    logic [31:0]        next_ms_left;
    logic [15:0]        sub;
    logic [15:0]        next_sub;
    logic [4:0]         widx;
    logic [4:0]         next_widx;
    logic               done;
    cpr_status_type     status;
    cpr_status_type     next_status;
    cpr_frame_type      frame;
    cpr_frame_type      next_frame;
    logic [31:0]        word;

    // word view: stamp low, stamp high, id, type word, then payload
    always_comb begin
        case (widx)
            5'd0:    word = frame.stamp[31:0];
            5'd1:    word = frame.stamp[63:32];
            5'd2:    word = frame.ident;
            5'd3:    word = {frame.kind, frame.info_a, frame.info_b, frame.length};
            default: word = frame.payload[(32'(widx) - 32'd4) * 32 +: 32];
        endcase
    end

    // overflow stays sticky until a read reports it; set wins over clear
    always_comb begin
        next_state       = state;
        next_over_sticky = over_sticky;
        next_ms_left     = ms_left;
        next_sub         = sub;
        next_widx        = widx;
        next_status      = status;
        next_frame       = frame;
        pop              = 1'b0;
        done             = 1'b0;
        case (state)
            CPR_IDLE: begin
                if (read_req_in) begin
                    next_ms_left = receive_wait_limit_in;
                    next_sub     = 16'h0000;
                    next_state   = CPR_WAIT;
                end
            end
            CPR_WAIT: begin
                if (store_valid) begin
                    pop              = 1'b1;
                    next_frame       = head;
                    next_status      = '{error: over_sticky, overflow: over_sticky,
                                         timeout: 1'b0};
                    next_over_sticky = 1'b0;
                    next_widx        = 5'd0;
                    next_state       = config_in.word_format ? CPR_WORD : CPR_SEND;
                end else if (ms_left == 32'h0) begin
                    next_status      = '{error: 1'b1, overflow: over_sticky, timeout: 1'b1};
                    next_over_sticky = 1'b0;
                    next_state       = CPR_SEND;
                end else if ($signed(ms_left) > 0) begin
                    if (sub == 16'(MS_CYC - 1)) begin
                        next_sub     = 16'h0000;
                        next_ms_left = ms_left - 32'h1;
                    end else begin
                        next_sub = sub + 16'h0001;
                    end
                end
            end
            CPR_SEND: begin
                done       = 1'b1;
                next_state = CPR_IDLE;
            end
            CPR_WORD: begin
                if (read_ready_in) begin
                    if (widx == 5'(`CPR_FRAME_WORDS - 1)) begin
                        done       = 1'b1;
                        next_state = CPR_IDLE;
                    end else begin
                        next_widx = widx + 5'd1;
                    end
                end
            end
            default: next_state = CPR_IDLE;
        endcase
        if (store_over) begin
            next_over_sticky = 1'b1;
        end
    end

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state       <= CPR_IDLE;
            over_sticky <= 1'b0;
            ms_left     <= 32'h0;
            sub         <= 16'h0000;
            widx        <= 5'd0;
            status      <= '0;
            frame       <= '0;
        end else begin
            state       <= next_state;
            over_sticky <= next_over_sticky;
            ms_left     <= next_ms_left;
            sub         <= next_sub;
            widx        <= next_widx;
            status      <= next_status;
            frame       <= next_frame;
        end
    end

    // busy holds later inputs of a shared request back
    assign read_busy_out             = (state != CPR_IDLE);
    assign read_done_out             = done;
    assign read_status_out           = status;
    assign received_frame_output_out = frame;
    assign word_valid_out            = (state == CPR_WORD);
    assign word_out                  = word;
    assign word_index_out            = widx;

endmodule : cpr_port
`default_nettype wire

// >>> test/cpr_port_monitor.sv
// Purpose: port checks of the CAN port block
// Assumes: one clock, async low reset
// Notes:   bound into every cpr_port
`timescale 1ns/10ps
`default_nettype none
module cpr_port_monitor (
    // clock and reset
    input wire logic                    mclk_in,
    input wire logic                    reset_n_in,
    // watched ports
    input wire cpr_pkg::cpr_config_type config_in,
    input wire logic signed [31:0]      receive_wait_limit_in,
    input wire logic                    tx_request_in,
    input wire logic                    tx_fail_in,
    input wire logic                    tx_start_out,
    input wire logic                    tx_refused_out,
    input wire logic                    ack_enable_out,
    input wire logic                    error_passive_out,
    input wire logic                    read_req_in,
    input wire logic                    read_busy_out,
    input wire logic                    read_done_out,
    input wire cpr_pkg::cpr_status_type read_status_out,
    input wire logic                    word_valid_out,
    input wire logic [4:0]              word_index_out
);
    import cpr_pkg::*;
    // one domain, so clock and reset are named once
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!reset_n_in);
    // options act at once, so the listen-only checks are same-cycle relations
    passive_err_a: assert property (config_in.listen_only |-> error_passive_out)
        else $error("listen only not error passive");
    ack_off_a: assert property (config_in.listen_only |-> !ack_enable_out)
        else $error("ack driven in listen only");
    tx_refuse_a: assert property (config_in.listen_only && tx_request_in
        |-> tx_refused_out && !tx_start_out) else $error("transmit not refused");
    retry_due_a: assert property (tx_fail_in && !config_in.single_shot
        |-> ##[0:8] tx_start_out) else $error("failed frame not retried");
    one_shot_a: assert property (tx_fail_in && config_in.single_shot
        |=> !tx_start_out [*4]) else $error("single shot retried");
    // read engine timing and outcome
    poll_due_a: assert property (read_req_in && !read_busy_out
        && receive_wait_limit_in == '0 && !config_in.word_format |-> ##2 read_done_out)
        else $error("poll not done in two cycles");
    err_flag_a: assert property (read_done_out
        && (read_status_out.timeout || read_status_out.overflow) |-> read_status_out.error)
        else $error("failed read without error");
    word_start_a: assert property ($rose(word_valid_out) |-> word_index_out == 5'h00)
        else $error("words not from first");
    // main scenarios
    cover property (read_done_out && read_status_out.overflow);
    cover property (tx_fail_in ##[1:8] tx_start_out);
    cover property (word_valid_out && word_index_out == 5'h13);
endmodule : cpr_port_monitor
bind cpr_port cpr_port_monitor mon_u (.*);
`default_nettype wire

// >>> test/cpr_bus_model.sv
// Purpose: protocol engine and far nodes as the port sees them
// Assumes: tasks are called right after a rising edge
// Notes:   released lines carry inverted data, not the last value
`timescale 1ns/10ps
`default_nettype none
module cpr_bus_model (
    // clock and reset
    input  wire logic    mclk_in,
    input  wire logic    reset_n_in,
    // attempt start from the port
    input  wire logic    tx_start_out,
    // events towards the port
    output logic         rx_done_in,
    output logic [31:0]  rx_ident_in,
    output logic [7:0]   rx_kind_in,
    output logic [7:0]   rx_length_in,
    output logic [511:0] rx_payload_in,
    output logic         bus_error_in,
    output logic [7:0]   bus_error_kind_in,
    output logic         tx_done_in,
    output logic         tx_fail_in
);
    logic [7:0] fails, attempts;
    // quiet bus at time zero
    initial begin
        {rx_done_in, bus_error_in, rx_ident_in, rx_kind_in, rx_length_in} = '0;
        {rx_payload_in, bus_error_kind_in, fails} = '0;
    end
    // prompt answer; the first fails attempts are lost on the bus
    always @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            {tx_done_in, tx_fail_in, attempts} <= '0;
        end else begin
            tx_done_in <= (tx_start_out === 1'b1) && (fails == 8'h00);
            tx_fail_in <= (tx_start_out === 1'b1) && (fails != 8'h00);
            if (tx_start_out === 1'b1) begin
                attempts <= attempts + 8'h01;
                fails <= (fails == 8'h00) ? 8'h00 : fails - 8'h01;
            end
        end
    end
    // one frame end or one bus error, then the lines are released
    task automatic event_out(input logic err, input logic [31:0] id, input logic [7:0] len);
        @(posedge mclk_in);
        rx_done_in <= !err;
        bus_error_in <= err;
        bus_error_kind_in <= 8'h06;
        {rx_ident_in, rx_length_in, rx_payload_in} <= {id, len, {16{id}}};
        @(posedge mclk_in);
        {rx_done_in, bus_error_in} <= 2'h0;
        bus_error_kind_in <= 8'hF9;
        {rx_ident_in, rx_length_in, rx_payload_in} <= ~{id, len, {16{id}}};
    endtask : event_out
endmodule : cpr_bus_model
`default_nettype wire

// >>> test/testbench.sv
// Purpose: self-checking bench of the CAN port block
// Assumes: auto start on, bus model answers attempts
// Notes:   scenarios share one reset and run in order
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import cpr_pkg::*;
    // ports of the block under test
    logic               mclk_in, reset_n_in, auto_start_in, start_in, stop_in, rx_done_in;
    logic               rx_fd_in, bus_error_in, tx_request_in, tx_done_in, tx_fail_in;
    logic               tx_start_out, tx_refused_out, ack_enable_out, error_passive_out;
    logic               running_out, read_req_in, read_ready_in, read_busy_out;
    logic               read_done_out, word_valid_out;
    logic [4:0]         word_index_out;
    logic [7:0]         rx_kind_in, rx_length_in, bus_error_kind_in, tx_length_in;
    logic [31:0]        rx_ident_in, tx_ident_in, word_out;
    logic [511:0]       rx_payload_in, tx_payload_in;
    logic signed [31:0] receive_wait_limit_in;
    cpr_config_type     config_in;
    cpr_status_type     read_status_out;
    cpr_frame_type      received_frame_output_out, got;
    logic [31:0]        words [0:20];
    int                 n_fail, checks_done;
    cpr_port dut_u (.*);
    cpr_bus_model bus_u (.*);
    // 20 MHz clock
    initial begin
        mclk_in = 1'b0;
        forever #25 mclk_in = ~mclk_in;
    end
    // --------
    // shared tasks
    // --------
    task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t %s got %0h want %0h", $time, what, seen, exp);
        end
    endtask : check
    task automatic summarize;
        $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : summarize
    // one read; outputs sampled on the falling edge, clear of updates
    task automatic rd(input logic signed [31:0] lim);
        int k;
        @(posedge mclk_in);
        read_req_in <= 1'b1;
        receive_wait_limit_in <= lim;
        @(posedge mclk_in);
        read_req_in <= 1'b0;
        for (k = 0; k < 200; k++) begin
            @(negedge mclk_in);
            if (word_valid_out === 1'b1) words[word_index_out] = word_out;
            if (read_done_out === 1'b1) break;
        end
        if (k == 200) begin
            n_fail++;
            summarize();
        end
        got = received_frame_output_out;
        @(posedge mclk_in);
    endtask : rd
    // one transmit request, then room for every attempt
    task automatic send_tx(input logic [7:0] f);
        @(posedge mclk_in);
        bus_u.fails <= f;
        tx_request_in <= 1'b1;
        @(posedge mclk_in);
        tx_request_in <= 1'b0;
        repeat (30) @(posedge mclk_in);
    endtask : send_tx
    // --------
    // scenarios
    // --------
    task automatic t_listen;
        @(posedge mclk_in);
        config_in.listen_only <= 1'b1;
        tx_request_in <= 1'b1;
        @(negedge mclk_in);
        check(tx_refused_out, 1'h1, "refuse");
        check(ack_enable_out, 1'h0, "ack off");
        check(error_passive_out, 1'h1, "passive");
        @(posedge mclk_in);
        config_in.listen_only <= 1'b0;
        tx_request_in <= 1'b0;
        @(negedge mclk_in);
        check(ack_enable_out, 1'h1, "ack on");
        check(bus_u.attempts, 8'h00, "no attempt");
    endtask : t_listen
    task automatic t_tx;
        tx_ident_in <= 32'h0000_0155;
        send_tx(8'h02);
        check(bus_u.attempts, 8'h03, "retries");
        rd(32'sh0);
        check(read_status_out.timeout, 1'h1, "no echo");
        config_in.single_shot <= 1'b1;
        send_tx(8'h01);
        check(bus_u.attempts, 8'h04, "one try");
        config_in.single_shot <= 1'b0;
        config_in.echo_on <= 1'b1;
        send_tx(8'h00);
        rd(32'sh1);
        check(got.ident, 32'h0000_0155, "echo");
        config_in.echo_on <= 1'b0;
    endtask : t_tx
    // restart, then three frames into a two-frame store
    task automatic t_rx;
        logic [63:0] s1;
        @(posedge mclk_in);
        stop_in <= 1'b1;
        @(posedge mclk_in);
        stop_in <= 1'b0;
        start_in <= 1'b1;
        @(posedge mclk_in);
        start_in <= 1'b0;
        repeat (6) @(posedge mclk_in);
        bus_u.event_out(1'b0, 32'h0000_0123, 8'h08);
        bus_u.event_out(1'b0, 32'h2000_0ABC, 8'h0C);
        bus_u.event_out(1'b0, 32'h0000_0456, 8'h01);
        rd(32'sh1);
        check({read_status_out.error, read_status_out.overflow}, 2'h3, "overflow");
        check(got.ident, 32'h0000_0123, "oldest");
        check(got.ident[29], 1'h0, "standard");
        check(got.stamp < 64'h10, 1'h1, "origin");
        s1 = got.stamp;
        rd(32'sh1);
        check(read_status_out, 3'h0, "second");
        check(got.ident[29], 1'h1, "extended");
        check(got.length, 8'h08, "length");
        check(got.stamp - s1, 64'h1, "stamp step");
        rd(32'sh0);
        check({read_status_out.error, read_status_out.timeout}, 2'h3, "poll");
    endtask : t_rx
    task automatic t_berr;
        config_in.log_bus_errors <= 1'b1;
        bus_u.event_out(1'b1, 32'h0000_0000, 8'h00);
        rd(32'sh1);
        check(got.kind, 8'h06, "error frame");
        config_in.log_bus_errors <= 1'b0;
    endtask : t_berr
    task automatic t_words;
        config_in.word_format <= 1'b1;
        read_ready_in <= 1'b1;
        bus_u.event_out(1'b0, 32'h0000_0789, 8'h04);
        rd(32'sh1);
        check(words[2], 32'h0000_0789, "id word");
        check(words[3][7:0], 8'h04, "length word");
        check(words[4], 32'h0000_0789, "data word");
        config_in.word_format <= 1'b0;
        read_ready_in <= 1'b0;
    endtask : t_words
    // reset, then every scenario in turn
    initial begin
        n_fail = 0;
        checks_done = 0;
        reset_n_in = 1'b0;
        auto_start_in = 1'b1;
        {start_in, stop_in, rx_fd_in, tx_request_in, read_req_in, read_ready_in} = '0;
        {tx_ident_in, tx_length_in, tx_payload_in, receive_wait_limit_in} = '0;
        config_in = '0;
        repeat (16) @(posedge mclk_in);
        reset_n_in <= 1'b1;
        repeat (4) @(posedge mclk_in);
        check(running_out, 1'h1, "auto start");
        t_listen();
        t_tx();
        t_rx();
        t_berr();
        t_words();
        summarize();
    end
endmodule : testbench
`default_nettype wire
